// ==== core/occ_output_compare_control.v ====
// Purpose: output compare channel control register one and its behaviour
// Assumes: single clock, time base ticks arrive as pulses from same-clock timers
// Notes: fault pins are asynchronous and pass a three-stage filter
//
// Function
// - With the idle-stop bit set the channel halts during idle, otherwise it keeps running.
// - The clock select field picks peripheral clock or timer 1, 5, 4, 3, 2 ticks; 110/101 reserved.
// - A fault input counts only while its enable bit is one.
// - Fault C flag is set by a fault on pin C.
// - Fault B flag is set by a fault on pin B.
// - Fault A flag is set by a fault on pin A.
// - With trigger clear mode set, the trigger status clears when secondary value equals timer.
// - With trigger clear mode clear, only software clears the trigger status.
// - Primary and secondary values are double-buffered in PWM mode only.
// - Bits 15 and 14 of control register one read as zero.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "occ_regs.vh"

module occ_output_compare_control (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Time base ticks and system state
  input wire timer_one_clock,
  input wire timer_two_clock,
  input wire timer_three_clock,
  input wire timer_four_clock,
  input wire timer_five_clock,
  input wire cpu_idle,
  input wire trigger_event,
  // Fault pins
  input wire fault_pin_a,
  input wire fault_pin_b,
  input wire fault_pin_c,
  // Channel outputs
  output reg compare_out,
  output wire irq
);

////////////////////////////////////////////////////////////////////////////////
reg [15:0] con1_r;
reg trig_status_r;
reg [15:0] pri_r;
reg [15:0] sec_r;
reg [15:0] pri_buf_r;
reg [15:0] sec_buf_r;
reg [15:0] tmr_r;
reg [2:0] ist_r;
reg [2:0] imsk_r;
reg [2:0] fs1_r;
reg [2:0] fs2_r;
reg [2:0] fs3_r;
reg [2:0] flt_lvl_r;
reg [2:0] flt_ev;
reg tick;
reg halted;
reg pwm_mode;
reg period_end;
reg sec_match;
reg [15:0] con1_rd;
reg [15:0] pri_nxt;
reg [15:0] sec_nxt;
reg [15:0] tmr_nxt;
reg out_nxt;
reg trig_nxt;
reg [2:0] ist_nxt;

wire [2:0] mode = con1_r[2:0];
wire [2:0] tsel = con1_r[`OCC_B_TSEL_HI:`OCC_B_TSEL_LO];
wire [2:0] flt_en = {con1_r[`OCC_B_ENFC], con1_r[`OCC_B_ENFB], con1_r[`OCC_B_ENFA]};
wire wr_con1 = reg_wr && (reg_addr == `OCC_ADDR_CON1);
wire wr_con2 = reg_wr && (reg_addr == `OCC_ADDR_CON2);

////////////////////////////////////////////////////////////////////////////////
// Time base selection and idle halt
always @* begin
  case (tsel)
    `OCC_TSEL_PER: tick = 1'b1;
    `OCC_TSEL_T1: tick = timer_one_clock;
    `OCC_TSEL_T5: tick = timer_five_clock;
    `OCC_TSEL_T4: tick = timer_four_clock;
    `OCC_TSEL_T3: tick = timer_three_clock;
    `OCC_TSEL_T2: tick = timer_two_clock;
    default: tick = 1'b0;
  endcase
end

// Halt gates every tick, so timer and matches freeze; while halted only a PWM fault or mode off drives the output low
always @* begin
  halted = cpu_idle && con1_r[`OCC_B_IDLE];
  pwm_mode = (mode == `OCC_MODE_PWM);
  period_end = tick && !halted && (tmr_r == pri_r);
  sec_match = tick && !halted && (tmr_r == sec_r);
end

////////////////////////////////////////////////////////////////////////////////
// Fault pins: three stages, a change counts when stages two and three agree
always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    fs1_r <= 3'h0;
    fs2_r <= 3'h0;
    fs3_r <= 3'h0;
    flt_lvl_r <= 3'h0;
  end else begin
    fs1_r <= {fault_pin_c, fault_pin_b, fault_pin_a};
    fs2_r <= fs1_r;
    fs3_r <= fs2_r;
    flt_lvl_r <= (fs2_r & fs3_r) | (flt_lvl_r & (fs2_r | fs3_r));
  end
end

always @* begin
  flt_ev = flt_lvl_r & flt_en;
end

////////////////////////////////////////////////////////////////////////////////
// Control register one
always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    con1_r <= `OCC_CON1_RST;
  end else begin
    if (wr_con1) begin
      con1_r <= reg_wdata & `OCC_CON1_WMASK;
    end
    // Set wins over a software write of zero
    if (flt_ev[2]) begin
      con1_r[`OCC_B_FLTC] <= 1'b1;
    end
    if (flt_ev[1]) begin
      con1_r[`OCC_B_FLTB] <= 1'b1;
    end
    if (flt_ev[0]) begin
      con1_r[`OCC_B_FLTA] <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Trigger status in control register two; a new trigger wins over any clear
always @* begin
  trig_nxt = trig_status_r;
  if (trigger_event) begin
    trig_nxt = 1'b1;
  end else if (wr_con2 && !reg_wdata[`OCC_B_TRGST]) begin
    trig_nxt = 1'b0;
  end else if (con1_r[`OCC_B_TRGM] && sec_match) begin
    trig_nxt = 1'b0;
  end
end

always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    trig_status_r <= 1'b0;
  end else begin
    trig_status_r <= trig_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Compare values: PWM writes land in the shadow, other modes go straight through
always @* begin
  pri_nxt = pri_r;
  if (reg_wr && reg_addr == `OCC_ADDR_PRI && !pwm_mode) begin
    pri_nxt = reg_wdata;
  end else if (pwm_mode && period_end) begin
    // Shadow loads only at the period boundary to avoid glitched pulses
    pri_nxt = pri_buf_r;
  end
end

always @* begin
  sec_nxt = sec_r;
  if (reg_wr && reg_addr == `OCC_ADDR_SEC && !pwm_mode) begin
    sec_nxt = reg_wdata;
  end else if (pwm_mode && period_end) begin
    sec_nxt = sec_buf_r;
  end
end

always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    pri_r <= 16'h0000;
    sec_r <= 16'h0000;
    pri_buf_r <= 16'h0000;
    sec_buf_r <= 16'h0000;
  end else begin
    if (reg_wr && reg_addr == `OCC_ADDR_PRI) begin
      pri_buf_r <= reg_wdata;
    end
    if (reg_wr && reg_addr == `OCC_ADDR_SEC) begin
      sec_buf_r <= reg_wdata;
    end
    pri_r <= pri_nxt;
    sec_r <= sec_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Timer runs only while a mode is selected and the channel is not halted
always @* begin
  tmr_nxt = tmr_r;
  if (reg_wr && reg_addr == `OCC_ADDR_TMR) begin
    tmr_nxt = reg_wdata;
  end else if (tick && !halted && mode != `OCC_MODE_OFF) begin
    tmr_nxt = period_end ? 16'h0000 : tmr_r + 16'h0001;
  end
end

always @* begin
  out_nxt = compare_out;
  if (mode == `OCC_MODE_OFF) begin
    out_nxt = 1'b0;
  end else if (pwm_mode && (|flt_ev)) begin
    // Fault drives the pin inactive at once, ahead of any match
    out_nxt = 1'b0;
  end else if (period_end) begin
    out_nxt = 1'b1;
  end else if (sec_match) begin
    out_nxt = 1'b0;
  end
end

always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    tmr_r <= 16'h0000;
    compare_out <= 1'b0;
  end else begin
    tmr_r <= tmr_nxt;
    compare_out <= out_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status (write one to clear) and mask
always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    ist_r <= 3'h0;
    imsk_r <= 3'h0;
  end else begin
    if (reg_wr && reg_addr == `OCC_ADDR_IMSK) begin
      imsk_r <= reg_wdata[2:0];
    end
    ist_r <= ist_nxt;
  end
end

always @* begin
  ist_nxt = ist_r | flt_ev;
  if (reg_wr && reg_addr == `OCC_ADDR_IST) begin
    // An event in the same cycle as the clear is kept
    ist_nxt = (ist_r & ~reg_wdata[2:0]) | flt_ev;
  end
end

assign irq = |(ist_r & imsk_r);

////////////////////////////////////////////////////////////////////////////////
// Read port, data in the cycle after the strobe
always @* begin
  con1_rd = con1_r;
  con1_rd[15:14] = 2'h0;
end

always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    reg_rdata <= 16'h0000;
  end else if (reg_rd) begin
    case (reg_addr)
      `OCC_ADDR_CON1: reg_rdata <= con1_rd;
      `OCC_ADDR_CON2: reg_rdata <= {9'h000, trig_status_r, 6'h00};
      `OCC_ADDR_PRI: reg_rdata <= pri_buf_r;
      `OCC_ADDR_SEC: reg_rdata <= sec_buf_r;
      `OCC_ADDR_TMR: reg_rdata <= tmr_r;
      `OCC_ADDR_IST: reg_rdata <= {13'h0000, ist_r};
      `OCC_ADDR_IMSK: reg_rdata <= {13'h0000, imsk_r};
      default: reg_rdata <= 16'h0000;
    endcase
  end else begin
    reg_rdata <= 16'h0000;
  end
end

endmodule // occ_output_compare_control

// ==== core/occ_regs.vh ====
// Purpose: constants for the output compare control block
// Assumes: 16-bit register port, word index addressing
// Notes: offsets other than control register one are local choices
`ifndef OCC_REGS_VH
`define OCC_REGS_VH
`define OCC_ADDR_W 3
`define OCC_ADDR_CON1 3'h0
`define OCC_ADDR_CON2 3'h1
`define OCC_ADDR_PRI 3'h2
`define OCC_ADDR_SEC 3'h3
`define OCC_ADDR_TMR 3'h4
`define OCC_ADDR_IST 3'h5
`define OCC_ADDR_IMSK 3'h6
`define OCC_CON1_WMASK 16'h3f8f
`define OCC_CON1_RST 16'h0000
`define OCC_B_IDLE 13
`define OCC_B_TSEL_HI 12
`define OCC_B_TSEL_LO 10
`define OCC_B_ENFC 9
`define OCC_B_ENFB 8
`define OCC_B_ENFA 7
`define OCC_B_FLTC 6
`define OCC_B_FLTB 5
`define OCC_B_FLTA 4
`define OCC_B_TRGM 3
`define OCC_B_TRGST 6
`define OCC_TSEL_PER 3'h7
`define OCC_TSEL_T1 3'h4
`define OCC_TSEL_T5 3'h3
`define OCC_TSEL_T4 3'h2
`define OCC_TSEL_T3 3'h1
`define OCC_TSEL_T2 3'h0
`define OCC_MODE_PWM 3'h6
`define OCC_MODE_OFF 3'h0
`endif

// ==== verification/occ_control_assertions.sv ====
// Purpose: port checks for compare control
// Assumes: one clock
// Notes: idle-stop bit is tracked from control writes
`timescale 1ns/1ps
module occ_control_checker (
  // Clock, reset and register port
  input wire clk,
  input wire rst_b,
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Channel
  input wire cpu_idle,
  input wire compare_out,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg halt_r;
  wire c1w = reg_wr && reg_addr == 3'h0;
  wire c1r = reg_rd && reg_addr == 3'h0;
  wire hold = halt_r && cpu_idle;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      halt_r <= 1'b0;
    else if (c1w)
      halt_r <= reg_wdata[13];
  end
  // Gap cycle keeps the written value unambiguous
  sequence wr_rd; c1w ##1 !reg_wr ##1 c1r; endsequence
  top_bits_a: assert property (c1r |=> reg_rdata[15:14] == 2'h0)
    else $error("upper bits set");
  mode_field_a: assert property (wr_rd |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3))
    else $error("mode lost");
  clock_sel_a: assert property (wr_rd |=> reg_rdata[12:10] == $past(reg_wdata[12:10], 3))
    else $error("select lost");
  trig_mode_a: assert property (wr_rd |=> reg_rdata[3] == $past(reg_wdata[3], 3))
    else $error("clear mode lost");
  fault_gate_a: assert property (c1r |=> (reg_rdata[6:4] & ~reg_rdata[9:7]) == 3'h0)
    else $error("flag without enable");
  halt_idle_a: assert property ($past(hold) && $past(hold, 2) |-> $stable(compare_out))
    else $error("moved while halted");
  irq_clear_a: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("irq dropped alone");
  read_quiet_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("stray read data");
  cover property (c1r ##1 reg_rdata[6:4] != 3'h0);
  cover property ($rose(irq));
  cover property (hold [*4]);
endmodule // occ_control_checker
bind occ_output_compare_control occ_control_checker i_occ_control_checker (.clk, .rst_b,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_idle, .compare_out, .irq);

// ==== verification/occ_far_model.sv ====
// Purpose: timer ticks and fault pins
// Assumes: timers share the block clock
// Notes: fault levels follow the bench request
`timescale 1ns/1ps
module occ_far_model (
  // Clock and control
  input wire clk,
  input wire [2:0] fault_req,
  // Far side
  output wire [4:0] ticks,
  output wire [2:0] fault_pins
);
  reg [3:0] cnt_r = 4'h0;
  always @(posedge clk) cnt_r <= cnt_r + 4'h1;
  // Synchronous ticks only, never a foreign clock
  assign ticks = {&cnt_r, &cnt_r[2:0], &cnt_r[1:0], cnt_r[0], 1'b1};
  assign fault_pins = fault_req;
endmodule // occ_far_model

// ==== verification/tb_top.sv ====
// Purpose: bench for compare control
// Assumes: far model drives ticks and faults
// Notes: flags read back over the port
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cpu_idle = 1'b0;
  reg trigger_event = 1'b0, hold = 1'b0;
  reg [2:0] reg_addr = 3'h0, flt = 3'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg [34:0] rows [0:3];
  wire [15:0] reg_rdata;
  wire [4:0] tk;
  wire [2:0] pin;
  wire irq, cmp;
  int miscompares = 0, checks_done = 0, cyc = 0, i, hi;
  always #12.5 clk = ~clk;
  occ_far_model i_occ_far_model (.clk, .fault_req(flt), .ticks(tk), .fault_pins(pin));
  occ_output_compare_control i_occ_output_compare_control (.clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_one_clock(tk[0]),
    .timer_two_clock(tk[1]), .timer_three_clock(tk[2]), .timer_four_clock(tk[3]),
    .timer_five_clock(tk[4]), .cpu_idle, .trigger_event, .fault_pin_a(pin[0]),
    .fault_pin_b(pin[1]), .fault_pin_c(pin[2]), .compare_out(cmp), .irq);
  task chk(input string n, input [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input [2:0] a, input [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [2:0] a, input [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    rows[0] = {3'h0, 16'hffff, 16'h3f8f};
    rows[1] = {3'h7, 16'hffff, 16'h0000};
    rows[2] = {3'h2, 16'h1234, 16'h1234};
    rows[3] = {3'h6, 16'hffff, 16'h0007};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(rows[i][34:32], rows[i][31:16]);
      rd(rows[i][34:32], rows[i][15:0]);
    end
    for (i = 0; i < 8; i++) begin
      wr(3'h0, 16'(i) << 10);
      rd(3'h0, 16'(i) << 10);
    end
    for (i = 0; i < 3; i++) begin
      wr(3'h0, 16'h0080 << i);
      flt <= 3'h1 << i;
      repeat (8) @(posedge clk);
      flt <= 3'h0;
      repeat (8) @(posedge clk);
      rd(3'h0, 16'h0090 << i);
    end
    chk("irq", {15'h0000, irq}, 16'h0001);
    rd(3'h5, 16'h0007);
    wr(3'h5, 16'h0007);
    #1 chk("irq", {15'h0000, irq}, 16'h0000);
    wr(3'h0, 16'h0000);
    flt <= 3'h7;
    repeat (8) @(posedge clk);
    flt <= 3'h0;
    rd(3'h0, 16'h0000);
    wr(3'h3, 16'h0010);
    wr(3'h2, 16'hffff);
    wr(3'h0, 16'h1c01);
    trigger_event <= 1'b1;
    @(posedge clk) trigger_event <= 1'b0;
    repeat (40) @(posedge clk);
    rd(3'h1, 16'h0040);
    wr(3'h1, 16'h0040);
    rd(3'h1, 16'h0040);
    wr(3'h1, 16'h0000);
    rd(3'h1, 16'h0000);
    trigger_event <= 1'b1;
    @(posedge clk) trigger_event <= 1'b0;
    wr(3'h0, 16'h1c09);
    wr(3'h4, 16'h0000);
    repeat (40) @(posedge clk);
    rd(3'h1, 16'h0000);
    wr(3'h0, 16'h3c01);
    cpu_idle <= 1'b1;
    repeat (20) @(posedge clk);
    cpu_idle <= 1'b0;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(3'h0, 16'h0000);
    // PWM: period of primary plus one, high until secondary matches
    wr(3'h2, 16'h00ff);
    wr(3'h3, 16'h0004);
    wr(3'h0, 16'h1c06);
    wr(3'h2, 16'h0009);
    wr(3'h4, 16'h0000);
    repeat (20) @(posedge clk);
    rd(3'h4, 16'h0015);
    rd(3'h2, 16'h0009);
    repeat (260) @(posedge clk);
    hi = 0;
    repeat (10) begin
      @(negedge clk);
      hi += cmp;
    end
    chk("duty", 16'(hi), 16'h0005);
    wr(3'h0, 16'h3c06);
    cpu_idle <= 1'b1;
    wr(3'h4, 16'h0003);
    @(negedge clk) hold = cmp;
    repeat (20) @(posedge clk);
    rd(3'h4, 16'h0003);
    chk("cmp", {15'h0000, cmp}, {15'h0000, hold});
    wr(3'h0, 16'h1c06);
    wr(3'h4, 16'h0003);
    repeat (3) @(posedge clk);
    rd(3'h4, 16'h0007);
    cpu_idle <= 1'b0;
    conclude;
  end
endmodule // tb_top
